// File: common/anpr_defs.vh
// constants for the next page register bank
`ifndef ANPR_DEFS_VH
`define ANPR_DEFS_VH
// register offsets (5-bit management address)
`define ANPR_ADDR_LOCAL      5'h07
`define ANPR_ADDR_PARTNER    5'h08
`define ANPR_ADDR_EXPANSION  5'h06
// field positions of a next page word
`define ANPR_BIT_MORE        15
`define ANPR_BIT_RSVD        14
`define ANPR_BIT_MSG         13
`define ANPR_BIT_COMPLY_ACK_FLAG        12
`define ANPR_BIT_TOGGLE      11
`define ANPR_CODE_HI         10
`define ANPR_CODE_LO         0
// expansion register page received position
`define ANPR_BIT_PAGE_RX     1
// reset values
`define ANPR_RST_LOCAL       16'h2001
`define ANPR_RST_PARTNER     16'h0000
`define ANPR_RST_EXPANSION   16'h0000
`endif

// File: src/anpr_word_pack.v
// packs the outgoing next page word from its fields
`timescale 1ns/1ps
`include "anpr_defs.vh"
module anpr_word_pack (
  // fields
  input  wire        more_pages_flag,
  input  wire        message_page_flag,
  input  wire        comply_ack_flag,
  input  wire        toggle_flag,
  input  wire [10:0] code_field,
  // packed word
  output wire [15:0] word
);
  // reserved position is always driven low on the wire
  assign word = {more_pages_flag, 1'b0, message_page_flag, comply_ack_flag,
                 toggle_flag, code_field};
endmodule // anpr_word_pack

// File: src/anpr_regs.v
// next page transmit and link partner next page register bank
`timescale 1ns/1ps
`include "anpr_defs.vh"
module anpr_regs (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // management register port
  input  wire [4:0]  mgmt_addr,
  input  wire [15:0] mgmt_wdata,
  input  wire        mgmt_wr,
  input  wire        mgmt_rd,
  output reg  [15:0] mgmt_rdata,
  // arbitration side
  input  wire        base_word_sent,
  input  wire        base_word_bit11,
  input  wire        page_sent,
  input  wire        partner_word_valid,
  input  wire [15:0] partner_word,
  // outgoing next page word
  output reg  [15:0] tx_next_page_word,
  output reg         page_received
);

  // layout: field registers for the local word and the partner word, the
  // latching page flag, then registered outputs; every field register and the
  // flag has its own next value so the capture strobes stay easy to follow
  // partner fields are stored apart, bit 14 is never stored at all

  // reset images; every field default is cut from these
  localparam [15:0] RST_LOCAL   = `ANPR_RST_LOCAL;
  localparam [15:0] RST_PARTNER = `ANPR_RST_PARTNER;
  localparam [15:0] RST_EXPANS  = `ANPR_RST_EXPANSION;

  // local word fields, written by management
  reg         more_q;
  reg         msg_q;
  reg         comply_ack_flag_q;
  reg  [10:0] code_q;

  // transmit toggle; software cannot write it, the line events drive it
  reg         toggle_q;

  // partner word fields, loaded together from the line side
  reg         p_more_q;
  reg         p_msg_q;
  reg         p_comply_ack_flag_q;
  reg         p_toggle_q;
  reg  [10:0] p_code_q;

  // latching page received flag behind the expansion register
  reg         page_rx_q;

  // next values of the local fields
  reg         more_d;
  reg         msg_d;
  reg         comply_ack_flag_d;
  reg  [10:0] code_d;
  reg         toggle_d;

  // next values of the partner fields and the flag
  reg         p_more_d;
  reg         p_msg_d;
  reg         p_comply_ack_flag_d;
  reg         p_toggle_d;
  wire [10:0] p_code_d;
  reg         page_rx_d;

  // read path and packed words
  reg  [15:0] rdata_d;
  wire [15:0] packed_word;
  wire [15:0] partner_view;
  wire [10:0] rx_code;

  // address match helper used by several decodes
  // full five-bit compare, so aliases of the offsets never hit
  function hit;
    input [4:0] a;
    input [4:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // field pickers, shared by the write path and the partner capture
  // one definition of each position keeps both words in step
  function pick_more;
    input [15:0] w;
    begin
      pick_more = w[`ANPR_BIT_MORE];
    end
  endfunction

  function pick_msg;
    input [15:0] w;
    begin
      pick_msg = w[`ANPR_BIT_MSG];
    end
  endfunction

  function pick_comply_ack_flag;
    input [15:0] w;
    begin
      pick_comply_ack_flag = w[`ANPR_BIT_COMPLY_ACK_FLAG];
    end
  endfunction

  function pick_toggle;
    input [15:0] w;
    begin
      pick_toggle = w[`ANPR_BIT_TOGGLE];
    end
  endfunction

  function [10:0] pick_code;
    input [15:0] w;
    begin
      pick_code = w[`ANPR_CODE_HI:`ANPR_CODE_LO];
    end
  endfunction

  // strobes qualified by address
  // writes to the partner or expansion offsets change nothing
  wire wr_local   = mgmt_wr & hit(mgmt_addr, `ANPR_ADDR_LOCAL);
  wire rd_local   = mgmt_rd & hit(mgmt_addr, `ANPR_ADDR_LOCAL);
  wire rd_partner = mgmt_rd & hit(mgmt_addr, `ANPR_ADDR_PARTNER);
  wire rd_expans  = mgmt_rd & hit(mgmt_addr, `ANPR_ADDR_EXPANSION);

  // local fields hold unless the local word is written;
  // toggle and reserved bit 14 are never taken from write data
  always @*
  begin
    more_d = more_q;
    msg_d  = msg_q;
    comply_ack_flag_d = comply_ack_flag_q;
    code_d = code_q;
    if (wr_local)
    begin
      more_d = pick_more(mgmt_wdata);
      msg_d  = pick_msg(mgmt_wdata);
      comply_ack_flag_d = pick_comply_ack_flag(mgmt_wdata);
      code_d = pick_code(mgmt_wdata);
    end
  end

  // toggle: base word seeds it, every sent page flips it;
  // base wins if both land together, since it restarts the exchange
  always @*
  begin
    toggle_d = toggle_q;
    if (base_word_sent)
      toggle_d = ~base_word_bit11;
    else if (page_sent)
      toggle_d = ~toggle_q;
  end

  // partner flags share one strobe so a read never mixes two words
  always @*
  begin
    p_more_d   = p_more_q;
    p_msg_d    = p_msg_q;
    p_comply_ack_flag_d   = p_comply_ack_flag_q;
    p_toggle_d = p_toggle_q;
    if (partner_word_valid)
    begin
      p_more_d   = pick_more(partner_word);
      p_msg_d    = pick_msg(partner_word);
      p_comply_ack_flag_d   = pick_comply_ack_flag(partner_word);
      p_toggle_d = pick_toggle(partner_word);
    end
  end

  // received code bits, one capture mux per bit under the same strobe
  assign rx_code = pick_code(partner_word);

  genvar gi;
  generate
    for (gi = 0; gi < 11; gi = gi + 1)
    begin : g_code
      assign p_code_d[gi] = partner_word_valid ? rx_code[gi]
                                               : p_code_q[gi];
    end
  endgenerate

  // latching page received: a new word wins over the clearing read,
  // otherwise a page landing in the read cycle would be lost unseen
  always @*
  begin
    page_rx_d = page_rx_q;
    if (rd_expans)
      page_rx_d = 1'b0;
    if (partner_word_valid)
      page_rx_d = 1'b1;
  end

  // read data mux; unmapped addresses and idle cycles read zero
  // registered below, so the data stand only in the cycle after the strobe
  always @*
  begin
    rdata_d = 16'h0000;
    if (rd_local)
      rdata_d = packed_word;
    else if (rd_partner)
      rdata_d = partner_view;
    else if (rd_expans)
    begin
      rdata_d                    = RST_EXPANS;
      rdata_d[`ANPR_BIT_PAGE_RX] = page_rx_q;
    end
  end

  // outgoing word assembly
  anpr_word_pack u_pack (
    .more_pages_flag   (more_q),
    .message_page_flag (msg_q),
    .comply_ack_flag   (comply_ack_flag_q),
    .toggle_flag       (toggle_q),
    .code_field        (code_q),
    .word              (packed_word)
  );

  // partner register image; the same packer keeps bit 14 low on read
  anpr_word_pack u_partner_pack (
    .more_pages_flag   (p_more_q),
    .message_page_flag (p_msg_q),
    .comply_ack_flag   (p_comply_ack_flag_q),
    .toggle_flag       (p_toggle_q),
    .code_field        (p_code_q),
    .word              (partner_view)
  );

  // local flags; defaults give a valid message page after reset
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      more_q <= RST_LOCAL[`ANPR_BIT_MORE];
      msg_q  <= RST_LOCAL[`ANPR_BIT_MSG];
      comply_ack_flag_q <= RST_LOCAL[`ANPR_BIT_COMPLY_ACK_FLAG];
    end
    else
    begin
      more_q <= more_d;
      msg_q  <= msg_d;
      comply_ack_flag_q <= comply_ack_flag_d;
    end
  end

  // local code field
  always @(posedge clk)
  begin
    if (sys_rst)
      code_q <= RST_LOCAL[`ANPR_CODE_HI:`ANPR_CODE_LO];
    else
      code_q <= code_d;
  end

  // transmit toggle
  always @(posedge clk)
  begin
    if (sys_rst)
      toggle_q <= RST_LOCAL[`ANPR_BIT_TOGGLE];
    else
      toggle_q <= toggle_d;
  end

  // partner flags
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      p_more_q   <= RST_PARTNER[`ANPR_BIT_MORE];
      p_msg_q    <= RST_PARTNER[`ANPR_BIT_MSG];
      p_comply_ack_flag_q   <= RST_PARTNER[`ANPR_BIT_COMPLY_ACK_FLAG];
      p_toggle_q <= RST_PARTNER[`ANPR_BIT_TOGGLE];
    end
    else
    begin
      p_more_q   <= p_more_d;
      p_msg_q    <= p_msg_d;
      p_comply_ack_flag_q   <= p_comply_ack_flag_d;
      p_toggle_q <= p_toggle_d;
    end
  end

  // partner code field
  always @(posedge clk)
  begin
    if (sys_rst)
      p_code_q <= RST_PARTNER[`ANPR_CODE_HI:`ANPR_CODE_LO];
    else
      p_code_q <= p_code_d;
  end

  // page received flag
  always @(posedge clk)
  begin
    if (sys_rst)
      page_rx_q <= RST_EXPANS[`ANPR_BIT_PAGE_RX];
    else
      page_rx_q <= page_rx_d;
  end

  // read data output, straight from a flop
  always @(posedge clk)
  begin
    if (sys_rst)
      mgmt_rdata <= 16'h0000;
    else
      mgmt_rdata <= rdata_d;
  end

  // outgoing word; lags its fields by one cycle, a cost of the flopped output
  always @(posedge clk)
  begin
    if (sys_rst)
      tx_next_page_word <= RST_LOCAL;
    else
      tx_next_page_word <= packed_word;
  end

  // flag pin mirrors the internal flag so pin and register never disagree
  always @(posedge clk)
  begin
    if (sys_rst)
      page_received <= RST_EXPANS[`ANPR_BIT_PAGE_RX];
    else
      page_received <= page_rx_d;
  end

endmodule // anpr_regs

// File: sim/anpr_link_partner.sv
// link partner stand-in driving the line-side pulses
`timescale 1ns/1ps
module anpr_link_partner (
  // clock
  input  wire        clk,
  // line side toward the register bank
  output reg         base_word_sent,
  output reg         base_word_bit11,
  output reg         page_sent,
  output reg         partner_word_valid,
  output reg  [15:0] partner_word
);
  initial {base_word_sent, base_word_bit11, page_sent, partner_word_valid, partner_word} = 0;
  // k is one-hot {word, page, base}; stale word inverted so it never passes for valid
  task send(input [2:0] k, input [15:0] w);
    @(posedge clk);
    {partner_word_valid, page_sent, base_word_sent} <= k;
    base_word_bit11 <= w[11];
    partner_word <= w;
    @(posedge clk);
    {partner_word_valid, page_sent, base_word_sent} <= 3'b000;
    base_word_bit11 <= ~w[11];
    partner_word <= ~w;
  endtask
endmodule // anpr_link_partner

// File: sim/anpr_regs_properties.sv
// assertions for the next page register bank
`timescale 1ns/1ps
`include "anpr_defs.vh"
module anpr_chk (
  // clock and reset
  input wire        clk,
  input wire        sys_rst,
  // management port
  input wire [4:0]  mgmt_addr,
  input wire [15:0] mgmt_wdata,
  input wire        mgmt_wr,
  input wire        mgmt_rd,
  input wire [15:0] mgmt_rdata,
  // arbitration side
  input wire        base_word_sent,
  input wire        base_word_bit11,
  input wire        page_sent,
  input wire        partner_word_valid,
  input wire [15:0] partner_word,
  // outgoing word and flag
  input wire [15:0] tx_next_page_word,
  input wire        page_received
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire [15:0] tx = tx_next_page_word;
  wire        rd6 = mgmt_rd && mgmt_addr == `ANPR_ADDR_EXPANSION;
  // word accepted, one quiet cycle, then a read of the partner register
  sequence s_rx_rd;
    partner_word_valid ##1 !partner_word_valid
      ##1 (mgmt_rd && mgmt_addr == `ANPR_ADDR_PARTNER);
  endsequence
  a_rd_idle: assert property (!$past(mgmt_rd) |-> mgmt_rdata == 16'h0000)
    else $error("read data outside slot");
  a_tog_flip: assert property (page_sent && !base_word_sent |-> ##2 tx[11] != $past(tx[11]))
    else $error("toggle not flipped");
  a_tog_init: assert property (base_word_sent |-> ##2 tx[11] == !$past(base_word_bit11, 2))
    else $error("bad first toggle");
  a_tog_same: assert property (mgmt_rd && mgmt_addr == `ANPR_ADDR_LOCAL |=> mgmt_rdata[11] == tx[11])
    else $error("toggle differs");
  a_code_copy: assert property (mgmt_wr && mgmt_addr == `ANPR_ADDR_LOCAL |-> ##2 tx[10:0] == $past(mgmt_wdata[10:0], 2))
    else $error("code not copied");
  a_rsvd_zero: assert property (mgmt_rdata[14] == 1'b0 && tx[14] == 1'b0)
    else $error("bit 14 set");
  a_rx_word: assert property (s_rx_rd |=> mgmt_rdata == ($past(partner_word, 3) & 16'hbfff))
    else $error("partner word wrong");
  a_rx_set: assert property (partner_word_valid |=> page_received)
    else $error("flag not set");
  a_rx_clr: assert property (rd6 && !partner_word_valid |=> !page_received && mgmt_rdata[1] == $past(page_received))
    else $error("flag read or clear wrong");
endmodule // anpr_chk
bind anpr_regs anpr_chk i_chk (.clk, .sys_rst, .mgmt_wr, .mgmt_rd, .base_word_sent,
  .base_word_bit11, .page_sent, .partner_word_valid, .page_received, .mgmt_addr,
  .mgmt_wdata, .mgmt_rdata, .partner_word, .tx_next_page_word);

// File: sim/testbench.sv
// self-checking bench for the next page register bank
`timescale 1ns/1ps
module testbench;
  reg         clk = 0, sys_rst = 1, mgmt_wr = 0, mgmt_rd = 0;
  reg  [4:0]  mgmt_addr = 0;
  reg  [15:0] mgmt_wdata = 0;
  wire [15:0] mgmt_rdata, tx_next_page_word, partner_word;
  wire        base_word_sent, base_word_bit11, page_sent, partner_word_valid, page_received;
  int         n_errors = 0, num_checks = 0;
  initial forever #5 clk = ~clk;
  anpr_link_partner i_partner (.clk, .base_word_sent, .base_word_bit11, .page_sent,
    .partner_word_valid, .partner_word);
  anpr_regs i_dut (.clk, .sys_rst, .mgmt_addr, .mgmt_wdata, .mgmt_wr, .mgmt_rd, .mgmt_rdata,
    .base_word_sent, .base_word_bit11, .page_sent, .partner_word_valid, .partner_word,
    .tx_next_page_word, .page_received);
  task chk(input [15:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [4:0] a, input [15:0] v);
    @(posedge clk);
    {mgmt_wr, mgmt_addr, mgmt_wdata} <= {1'b1, a, v};
    @(posedge clk);
    mgmt_wr <= 0;
  endtask
  // read data only valid in the cycle after the strobe
  task rd(input [4:0] a, input [15:0] exp);
    @(posedge clk);
    {mgmt_rd, mgmt_addr} <= {1'b1, a};
    @(posedge clk);
    mgmt_rd <= 0;
    #1 chk(mgmt_rdata, exp);
  endtask
  // outgoing word lags its fields by one cycle
  task txc(input [15:0] exp);
    @(posedge clk);
    #1 chk(tx_next_page_word, exp);
  endtask
  task summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #5000 n_errors++;
    summarize;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    rd(5'h07, 16'h2001);
    rd(5'h08, 16'h0000);
    rd(5'h06, 16'h0000);
    rd(5'h1f, 16'h0000);
    wr(5'h07, 16'h9fff);
    txc(16'h97ff);
    wr(5'h08, 16'hffff);
    rd(5'h08, 16'h0000);
    i_partner.send(3'b001, 16'h0000);
    txc(16'h9fff);
    i_partner.send(3'b001, 16'h0800);
    txc(16'h97ff);
    for (int i = 0; i < 2; i++)
    begin
      i_partner.send(3'b010, 16'h0000);
      txc(i ? 16'h97ff : 16'h9fff);
    end
    i_partner.send(3'b100, 16'hf555);
    #1 chk({15'h0, page_received}, 16'h0001);
    rd(5'h08, 16'hb555);
    rd(5'h06, 16'h0002);
    chk({15'h0, page_received}, 16'h0000);
    rd(5'h06, 16'h0000);
    // a page landing in the clearing read cycle must survive it
    fork
      i_partner.send(3'b100, 16'h0000);
      rd(5'h06, 16'h0000);
    join
    rd(5'h06, 16'h0002);
    i_partner.send(3'b100, 16'h4aaa);
    rd(5'h08, 16'h0aaa);
    summarize;
  end
endmodule // testbench
